// ===== inc/xirq_defs.svh
// Constants for the extra external interrupt and nibble port block.
// Assumes the core presents special-function accesses at 8-bit addresses.
`ifndef XIRQ_DEFS_SVH
`define XIRQ_DEFS_SVH

// ----------------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------------
`define XIRQ_CTRL_ADDR 8'hc0
`define XIRQ_PORT_ADDR 8'hd8

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define XIRQ_C_PRI_BIT 7
`define XIRQ_C_EN_BIT 6
`define XIRQ_C_FLAG_BIT 5
`define XIRQ_C_EDGE_BIT 4
`define XIRQ_B_PRI_BIT 3
`define XIRQ_B_EN_BIT 2
`define XIRQ_B_FLAG_BIT 1
`define XIRQ_B_EDGE_BIT 0

// ----------------------------------------------------------------------
// Reset values and vectors
// ----------------------------------------------------------------------
`define XIRQ_CTRL_RESET 8'h00
`define XIRQ_PORT_RESET 4'hf
`define XIRQ_VEC_BASE 8'h03
`define XIRQ_VEC_STRIDE 8'h08
`define XIRQ_SRC_B 3'h6
`define XIRQ_SRC_C 3'h7

`endif

// ===== inc/xirq_pkg.sv
// Types shared by the extra interrupt block and its testbench.
// Assumes nothing beyond a SystemVerilog compiler.
package xirq_pkg;

  // One special-function access from the core, byte or single bit.
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic bit_set;
    logic bit_clr;
  } sfr_req_s;

  // The interrupt offered to the core.
  typedef struct packed {
    logic valid;
    logic high;
    logic [2:0] src;
    logic [7:0] vector;
  } irq_grant_s;

endpackage : xirq_pkg

// ===== hw/ext_irq_detect.sv
// Edge or level detector and flag for one extra external interrupt input.
// Assumes the pin has already passed a two-stage synchroniser.
`timescale 1ns/1ps
module ext_irq_detect (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic pin_sync,
  input wire logic edge_sel,
  input wire logic serviced,
  input wire logic sw_wr,
  input wire logic sw_val,
  output logic flag_reg
);

  logic prev_reg;
  logic fall;
  logic flag_next;

  // Falling edge seen on the synchronised pin; an edge beats any clear.
  assign fall = prev_reg & ~pin_sync;
  assign flag_next = !edge_sel ? ~pin_sync :
                     fall ? 1'b1 :
                     serviced ? 1'b0 :
                     sw_wr ? sw_val : flag_reg;

  // Flag and previous pin level.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev_reg <= 1'b1;
      flag_reg <= 1'b0;
    end else begin
      prev_reg <= pin_sync;
      flag_reg <= flag_next;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_EDGE_SETS: assert property (edge_sel && fall |=> flag_reg)
    else $error("Falling edge did not set the flag.");
  AST_LEVEL_FOLLOWS: assert property (
    !edge_sel |=> flag_reg == !$past(pin_sync))
    else $error("Level mode flag does not follow the pin.");
  AST_SERVICE_CLEARS: assert property (
    edge_sel && serviced && !fall |=> !flag_reg)
    else $error("Service did not clear the edge flag.");

endmodule : ext_irq_detect

// ===== hw/extra_ext_irq.sv
// Extra external interrupts, eight-source arbiter and four-bit port.
// Assumes the core gives one SFR access per cycle on ref_clk, handles the
// six standard sources itself and acknowledges each grant with irq_ack.
`timescale 1ns/1ps
`include "xirq_defs.svh"
// Behaviour
// - Two extra external interrupts b and c act like standard ones.
// - Control register at 0c0h, bit-addressable; bit 0c2h enables b.
// - Priority bit set makes that interrupt high priority, else low.
// - Interrupt c enabled by control bit 6, b by bit 2.
// - Edge-select set means falling edge trigger, clear means low level.
// - Edge mode flag set by hardware on edge, cleared on service.
// - Interrupt b vectors to 33h and polls seventh.
// - Interrupt c vectors to 3bh and polls last.
// - Other six sources vector 03h to 2bh in fixed order.
// - Port at 0d8h, bit-addressable, four bits, quasi-bidirectional.
// - Port bits 2 and 3 double as interrupt inputs b and c.
// - Port write drives pins, read returns pins, bit ops change bits.
// - Reset sets port latches to ones, control register to zero.
module extra_ext_irq #(
  parameter int PORT_W = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input xirq_pkg::sfr_req_s sfr,
  output logic [7:0] sfr_rdata_reg,
  output logic sfr_hit_reg,
  input wire logic [5:0] core_req,
  input wire logic [5:0] core_pri,
  input wire logic irq_ack,
  input wire logic irq_reti,
  output xirq_pkg::irq_grant_s grant_reg,
  output logic [1:0] in_service_reg,
  input wire logic [PORT_W-1:0] nibble_port_i,
  output logic [PORT_W-1:0] nibble_port_o_reg,
  output logic [PORT_W-1:0] nibble_port_oe_reg
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [PORT_W-1:0] latch_reg;
  logic [PORT_W-1:0] pin_meta_reg;
  logic [PORT_W-1:0] pin_sync_reg;
  logic flag_b;
  logic flag_c;

  // --------------------------------------------------------------------
  // Register access decode
  // --------------------------------------------------------------------
  wire ctrl_sel = sfr.addr == `XIRQ_CTRL_ADDR;
  wire port_sel = sfr.addr == `XIRQ_PORT_ADDR;
  wire bit_op = sfr.bit_set | sfr.bit_clr;
  wire ctrl_bsel = sfr.addr[7:3] == 5'(`XIRQ_CTRL_ADDR >> 3);
  wire port_bsel = sfr.addr[7:3] == 5'(`XIRQ_PORT_ADDR >> 3);
  wire [7:0] bit_mask = 8'h01 << sfr.addr[2:0];
  wire [7:0] ctrl_view;
  wire [7:0] port_latch8 = {{(8-PORT_W){1'b0}}, latch_reg};
  wire [7:0] port_pins8 = {{(8-PORT_W){1'b0}}, pin_sync_reg};

  // Control view merges stored bits with the two live flags.
  assign ctrl_view = {ctrl_reg[7:6], flag_c, ctrl_reg[4:2], flag_b,
                      ctrl_reg[0]};

  // Byte write or single-bit read-modify-write of either register.
  wire ctrl_we = (sfr.wr & ctrl_sel) | (bit_op & ctrl_bsel);
  wire port_we = (sfr.wr & port_sel) | (bit_op & port_bsel);
  wire [7:0] ctrl_wval = sfr.wr ? sfr.wdata :
                         sfr.bit_set ? ctrl_view | bit_mask :
                         ctrl_view & ~bit_mask;
  wire [7:0] port_wval = sfr.wr ? sfr.wdata :
                         sfr.bit_set ? port_latch8 | bit_mask :
                         port_latch8 & ~bit_mask;
  wire [7:0] rd_val = ctrl_sel ? ctrl_view :
                      port_sel ? port_pins8 : 8'h00;

  // --------------------------------------------------------------------
  // Arbitration
  // --------------------------------------------------------------------
  wire en_b = ctrl_reg[`XIRQ_B_EN_BIT];
  wire en_c = ctrl_reg[`XIRQ_C_EN_BIT];
  wire [7:0] req = {en_c & flag_c, en_b & flag_b, core_req};
  wire [7:0] pri = {ctrl_reg[`XIRQ_C_PRI_BIT],
                    ctrl_reg[`XIRQ_B_PRI_BIT], core_pri};
  wire [7:0] hi_req = req & pri;
  wire any_hi = |hi_req;
  wire [2:0] pick;
  wire allow;
  wire [7:0] vec;

  // Lowest polling position among the set bits.
  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : first_set

  // High first, then position; a new request must outrank service.
  assign pick = first_set(any_hi ? hi_req : req);
  assign allow = (|req) && !in_service_reg[1] &&
                 (any_hi || !in_service_reg[0]);
  assign vec = `XIRQ_VEC_BASE + {2'b00, pick, 3'b000};

  // A stray acknowledge with no grant up must not clear a pending flag.
  wire serv_b = irq_ack && grant_reg.valid &&
                grant_reg.src == `XIRQ_SRC_B;
  wire serv_c = irq_ack && grant_reg.valid &&
                grant_reg.src == `XIRQ_SRC_C;

  // --------------------------------------------------------------------
  // Extra interrupt inputs on port bits 2 and 3
  // --------------------------------------------------------------------
  ext_irq_detect u_det_b (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_sync(pin_sync_reg[2]),
    .edge_sel(ctrl_reg[`XIRQ_B_EDGE_BIT]),
    .serviced(serv_b),
    .sw_wr(ctrl_we),
    .sw_val(ctrl_wval[`XIRQ_B_FLAG_BIT]),
    .flag_reg(flag_b)
  );
  ext_irq_detect u_det_c (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_sync(pin_sync_reg[3]),
    .edge_sel(ctrl_reg[`XIRQ_C_EDGE_BIT]),
    .serviced(serv_c),
    .sw_wr(ctrl_we),
    .sw_val(ctrl_wval[`XIRQ_C_FLAG_BIT]),
    .flag_reg(flag_c)
  );

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  // Control register, port latch and the pin outputs.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ctrl_reg <= `XIRQ_CTRL_RESET;
      latch_reg <= `XIRQ_PORT_RESET;
      nibble_port_o_reg <= `XIRQ_PORT_RESET;
      nibble_port_oe_reg <= '0;
    end else begin
      if (ctrl_we) begin
        ctrl_reg <= ctrl_wval;
      end
      if (port_we) begin
        latch_reg <= port_wval[PORT_W-1:0];
        nibble_port_o_reg <= port_wval[PORT_W-1:0];
        nibble_port_oe_reg <= ~port_wval[PORT_W-1:0];
      end
    end
  end

  // Two-stage synchroniser on the port pins.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta_reg <= '1;
      pin_sync_reg <= '1;
    end else begin
      pin_meta_reg <= nibble_port_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Read data is captured on the read strobe.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sfr_rdata_reg <= 8'h00;
      sfr_hit_reg <= 1'b0;
    end else if (sfr.rd) begin
      sfr_rdata_reg <= rd_val;
      sfr_hit_reg <= ctrl_sel | port_sel;
    end
  end

  // Grant to the core; withdrawn in the cycle after an acknowledge.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      grant_reg <= '0;
    end else begin
      grant_reg.valid <= allow && !irq_ack;
      grant_reg.high <= any_hi;
      grant_reg.src <= pick;
      grant_reg.vector <= vec;
    end
  end

  // Service level: bit 1 high, bit 0 low; return ends the higher.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      in_service_reg <= 2'b00;
    end else if (irq_ack && grant_reg.valid) begin
      in_service_reg[grant_reg.high ? 1 : 0] <= 1'b1;
    end else if (irq_reti) begin
      if (in_service_reg[1]) begin
        in_service_reg[1] <= 1'b0;
      end else begin
        in_service_reg[0] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_ack_taken;
    irq_ack && grant_reg.valid;
  endsequence
  sequence s_withdrawn;
    !grant_reg.valid;
  endsequence

  AST_ACK_WITHDRAWS: assert property (s_ack_taken |=> s_withdrawn)
    else $error("Grant stayed up after acknowledge.");
  AST_VECTOR_MAP: assert property (grant_reg.valid |->
    grant_reg.vector == 8'h03 + 8'(grant_reg.src) * 8'h08)
    else $error("Vector does not match the source position.");
  AST_NO_LOW_OVER_HIGH: assert property (
    in_service_reg[1] |=> !grant_reg.valid)
    else $error("Grant offered during high priority service.");
  AST_B_DISABLED: assert property (!en_b |-> !req[6])
    else $error("Disabled interrupt b requested.");
  AST_PORT_OE: assert property (
    nibble_port_oe_reg == ~nibble_port_o_reg)
    else $error("Port drive does not match latch.");
  AST_BIT_SET_C2: assert property (
    sfr.bit_set && sfr.addr == 8'hc2 |=> ctrl_reg[2])
    else $error("Bit set at c2 did not enable interrupt b.");
  AST_PORT_READ: assert property (sfr.rd && port_sel |=>
    sfr_rdata_reg[3:0] == $past(pin_sync_reg, 1))
    else $error("Port read does not return pin status.");
  // The granted source must have been a high request in the cycle before,
  // since priority bits may change in the cycle the grant appears.
  AST_HIGH_FIRST: assert property (allow && any_hi |=>
    grant_reg.high && ((($past(hi_req) >> grant_reg.src) & 8'h01) != 8'h00) ||
    $past(irq_ack))
    else $error("Low priority granted over a high one.");

endmodule : extra_ext_irq

// ===== verification/pin_model.sv
// Pin model for the four-bit port and the two interrupt sources on it.
// Assumes the design only ever drives a pin low, while its enable is high.
`timescale 1ns/1ps
module pin_model (
  input wire logic [3:0] drive_low,
  input wire logic [3:0] ext_low,
  output logic [3:0] pins
);
  // A pin idles high on its pull-up unless either party pulls it low.
  assign pins = ~(drive_low | ext_low);
endmodule : pin_model

// ===== verification/testbench.sv
// Self-checking bench for the extra interrupts and the nibble port.
// Assumes the package, header, design and pin model are compiled first.
`timescale 1ns/1ps
`include "xirq_defs.svh"
module testbench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  xirq_pkg::sfr_req_s sfr = '0;
  logic [7:0] rdata;
  logic hit;
  logic [5:0] core_req = 6'h00;
  logic [5:0] core_pri = 6'h00;
  logic irq_ack = 1'b0;
  logic irq_reti = 1'b0;
  xirq_pkg::irq_grant_s grant;
  logic [1:0] in_svc;
  logic [3:0] pins;
  logic [3:0] p_o;
  logic [3:0] p_oe;
  logic [3:0] ext_low = 4'h0;
  logic [31:0] rng = 32'd69181;
  int n_fail = 0;
  int tests_run = 0;

  // Free-running 125 MHz clock.
  always #4 ref_clk = ~ref_clk;

  extra_ext_irq i_extra_ext_irq (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .sfr(sfr), .sfr_rdata_reg(rdata), .sfr_hit_reg(hit),
    .core_req(core_req), .core_pri(core_pri), .irq_ack(irq_ack),
    .irq_reti(irq_reti), .grant_reg(grant), .in_service_reg(in_svc),
    .nibble_port_i(pins), .nibble_port_o_reg(p_o),
    .nibble_port_oe_reg(p_oe));
  pin_model i_pin_model (.drive_low(p_oe), .ext_low(ext_low), .pins(pins));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // Advances the seed; the bench starts every draw from it.
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  // High requests first, then the lowest position wins.
  function automatic xirq_pkg::irq_grant_s exp_grant(
      input logic [5:0] req, input logic [5:0] pri);
    xirq_pkg::irq_grant_s g;
    logic [5:0] m;
    g = '0;
    g.high = (req & pri) != 6'h00;
    m = g.high ? (req & pri) : req;
    for (int k = 5; k >= 0; k--) begin
      if (m[k]) begin
        g.src = 3'(k);
      end
    end
    g.valid = 1'b1;
    g.vector = 8'h03 + {2'b00, g.src, 3'b000};
    return g;
  endfunction : exp_grant

  task automatic stop_test;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check8

  task automatic check_grant(input xirq_pkg::irq_grant_s exp);
    tests_run++;
    if (grant !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, grant, exp);
    end
  endtask : check_grant

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  // One access, then one idle cycle so that back-to-back calls never
  // assign the request twice in one time step; kind is
  // {wr, rd, bit_set, bit_clr}.
  task automatic acc(input logic [3:0] kind, input logic [7:0] a,
      input logic [7:0] d);
    sfr.addr = a;
    sfr.wdata = d;
    {sfr.wr, sfr.rd, sfr.bit_set, sfr.bit_clr} = kind;
    tick(1);
    sfr = '0;
    tick(1);
  endtask : acc

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
      input logic h);
    acc(4'b0100, a, 8'h00);
    check8(rdata, e);
    check8({7'h00, hit}, {7'h00, h});
  endtask : rd_chk

  task automatic wait_grant;
    for (int i = 0; i < 20 && grant.valid !== 1'b1; i++) begin
      tick(1);
    end
  endtask : wait_grant

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  // Reset, port, control register, interrupts, then random arbitration.
  initial begin
    tick(4);
    sys_rst = 1'b0;
    rd_chk(`XIRQ_CTRL_ADDR, 8'h00, 1'b1);
    rd_chk(`XIRQ_PORT_ADDR, 8'h0f, 1'b1);
    rd_chk(8'h80, 8'h00, 1'b0);
    check8({p_o, p_oe}, 8'hf0);
    $display("test reset done");
    acc(4'b1000, `XIRQ_PORT_ADDR, 8'hfa);
    tick(4);
    check8({p_o, p_oe}, 8'ha5);
    rd_chk(`XIRQ_PORT_ADDR, 8'h0a, 1'b1);
    acc(4'b0010, 8'hd8, 8'h00);
    acc(4'b0001, 8'hd9, 8'h00);
    tick(4);
    rd_chk(`XIRQ_PORT_ADDR, 8'h09, 1'b1);
    acc(4'b1000, `XIRQ_PORT_ADDR, 8'hff);
    acc(4'b0010, 8'hc2, 8'h00);
    rd_chk(`XIRQ_CTRL_ADDR, 8'h04, 1'b1);
    $display("test port and bits done");
    acc(4'b1000, `XIRQ_CTRL_ADDR, 8'h50);
    tick(4);
    ext_low[3] = 1'b1;
    wait_grant();
    check_grant({1'b1, 1'b0, 3'h7, 8'h3b});
    rd_chk(`XIRQ_CTRL_ADDR, 8'h70, 1'b1);
    irq_ack = 1'b1;
    tick(1);
    irq_ack = 1'b0;
    tick(2);
    check8({grant.valid, 5'h00, in_svc}, 8'h01);
    rd_chk(`XIRQ_CTRL_ADDR, 8'h50, 1'b1);
    ext_low[3] = 1'b0;
    irq_reti = 1'b1;
    tick(1);
    irq_reti = 1'b0;
    $display("test edge interrupt done");
    acc(4'b1000, `XIRQ_CTRL_ADDR, 8'h0c);
    core_req = 6'h01;
    ext_low[2] = 1'b1;
    tick(6);
    check_grant({1'b1, 1'b1, 3'h6, 8'h33});
    ext_low[2] = 1'b0;
    acc(4'b1000, `XIRQ_CTRL_ADDR, 8'h00);
    tick(6);
    $display("test level priority done");
    for (int n = 0; n < 40; n++) begin
      rng = xorshift(rng);
      core_req = rng[5:0] | 6'h20;
      core_pri = rng[13:8];
      tick(2);
      check_grant(exp_grant(core_req, core_pri));
    end
    $display("test random arbitration done");
    stop_test();
  end

  // Cuts a hang short well past the 150 or so cycles the tests need.
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
endmodule : testbench
